// *** include/rdbc_pkg.sv ***
// Constants for the reverse-drive and active-braking configuration register.
// Assumes a 32-bit AXI4-Lite register bus with 12-bit byte addresses.
//
// Contract
// - Register at index 82h, resets to zero
// - Bits 30-27 select linear reverse acceleration
// - Bits 26-23 select quadratic reverse acceleration
// - Bits 22-20 select braking bus current limit
// - Bits 19-10 give braking proportional gain
// - Bits 9-0 give braking integral gain
package rdbc_pkg;

  // ----------------------------------------------------------------------
  // Bus layout
  // ----------------------------------------------------------------------
  localparam int          RDBC_ADDR_W      = 12;
  localparam int          RDBC_DATA_W      = 32;
  localparam int          RDBC_STRB_W      = 4;
  localparam logic [11:0] RDBC_REG_INDEX   = 12'h082;
  localparam int          RDBC_WORD_LSB    = 2;
  // Offset counts words, so the byte address is four times the index
  localparam logic [11:0] RDBC_REG_ADDR    = RDBC_REG_INDEX << RDBC_WORD_LSB;
  localparam logic [1:0]  RDBC_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RDBC_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Register fields
  // ----------------------------------------------------------------------
  localparam logic [31:0] RDBC_CFG_RESET  = 32'h00000000;
  localparam logic [31:0] RDBC_WRITE_MASK = 32'h7fffffff;
  localparam int          RDBC_A1_MSB     = 30;
  localparam int          RDBC_A1_LSB     = 27;
  localparam int          RDBC_A2_MSB     = 26;
  localparam int          RDBC_A2_LSB     = 23;
  localparam int          RDBC_ILIM_MSB   = 22;
  localparam int          RDBC_ILIM_LSB   = 20;
  localparam int          RDBC_KP_MSB     = 19;
  localparam int          RDBC_KP_LSB     = 10;
  localparam int          RDBC_KI_MSB     = 9;
  localparam int          RDBC_KI_LSB     = 0;

  // ----------------------------------------------------------------------
  // Code tables
  // ----------------------------------------------------------------------
  // Acceleration in units of 0.01 Hz/s (or Hz/s2)
  localparam logic [19:0] RDBC_A1_TABLE [16] = '{
    20'h00001, 20'h00005, 20'h00064, 20'h000fa,
    20'h001f4, 20'h003e8, 20'h009c4, 20'h01388,
    20'h01d4c, 20'h02710, 20'h061a8, 20'h0c350,
    20'h00000, 20'h186a0, 20'h00000, 20'hf4240};
  localparam logic [15:0] RDBC_A1_RSVD = 16'h5000;
  localparam logic [19:0] RDBC_A2_TABLE [16] = '{
    20'h00000, 20'h00005, 20'h00064, 20'h000fa,
    20'h001f4, 20'h003e8, 20'h009c4, 20'h01388,
    20'h01d4c, 20'h02710, 20'h061a8, 20'h0c350,
    20'h124f8, 20'h186a0, 20'h7a120, 20'hf4240};
  // Current limit in units of 1/16 A
  localparam logic [7:0]  RDBC_ILIM_TABLE [8] = '{
    8'h05, 8'h0a, 8'h14, 8'h1e, 8'h28, 8'h32, 8'h3c, 8'h00};
  localparam logic [2:0]  RDBC_ILIM_RSVD  = 3'h7;

endpackage

// *** src/rdbc_decode.sv ***
// Field decoder for the reverse-drive and braking configuration word.
// Purely combinational; the caller registers the results.
`timescale 1ns/10ps
`default_nettype none

module rdbc_decode
(
  // Configuration word
  input  wire logic [31:0] cfg,
  // Decoded settings
  output logic      [19:0] lin_accel,
  output logic             lin_accel_rsvd,
  output logic      [19:0] quad_accel,
  output logic      [7:0]  brake_ilim,
  output logic             brake_ilim_rsvd
);
  import rdbc_pkg::*;

  function automatic logic [19:0] accel_lookup(input logic [3:0] code,
                                               input logic       quad);
    accel_lookup = quad ? RDBC_A2_TABLE[code] : RDBC_A1_TABLE[code];
  endfunction

  always_comb
  begin
    lin_accel       = accel_lookup(cfg[RDBC_A1_MSB:RDBC_A1_LSB], 1'b0);
    // Unlisted codes decode to zero and are flagged
    lin_accel_rsvd  = RDBC_A1_RSVD[cfg[RDBC_A1_MSB:RDBC_A1_LSB]];
    quad_accel      = accel_lookup(cfg[RDBC_A2_MSB:RDBC_A2_LSB], 1'b1);
    brake_ilim      = RDBC_ILIM_TABLE[cfg[RDBC_ILIM_MSB:RDBC_ILIM_LSB]];
    brake_ilim_rsvd = cfg[RDBC_ILIM_MSB:RDBC_ILIM_LSB] == RDBC_ILIM_RSVD;
  end

endmodule

`default_nettype wire

// *** src/rdbc_top.sv ***
// AXI4-Lite slave holding the reverse-drive and active-braking register,
// with registered decoded settings for the motor-control algorithm.
// Assumes one clock, synchronous active-low reset, one master.
`timescale 1ns/10ps
`default_nettype none

module rdbc_top
(
  // Clock and reset
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  // Write address channel
  input  wire logic [rdbc_pkg::RDBC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  // Write data channel
  input  wire logic [rdbc_pkg::RDBC_DATA_W-1:0] s_axi_wdata,
  input  wire logic [rdbc_pkg::RDBC_STRB_W-1:0] s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  // Write response channel
  output logic      [1:0]                       s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  // Read address channel
  input  wire logic [rdbc_pkg::RDBC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  // Read data channel
  output logic      [rdbc_pkg::RDBC_DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]                       s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  // Settings to the motor-control algorithm
  output logic      [19:0]                      lin_accel_q,
  output logic                                  lin_accel_rsvd_q,
  output logic      [19:0]                      quad_accel_q,
  output logic      [7:0]                       brake_ilim_q,
  output logic                                  brake_ilim_rsvd_q,
  output logic      [9:0]                       brake_kp_q,
  output logic      [9:0]                       brake_ki_q
);
  import rdbc_pkg::*;

  // ----------------------------------------------------------------------
  // Storage and decode
  // ----------------------------------------------------------------------
  logic [31:0]            cfg_q;
  logic [RDBC_ADDR_W-1:0] awaddr_q;
  logic [31:0]            wdata_q;
  logic [3:0]             wstrb_q;
  logic                   aw_done_q;
  logic                   w_done_q;
  logic                   wr_fire;
  logic                   wr_hit;
  logic [19:0]            lin_accel_d;
  logic                   lin_accel_rsvd_d;
  logic [19:0]            quad_accel_d;
  logic [7:0]             brake_ilim_d;
  logic                   brake_ilim_rsvd_d;

  function automatic logic addr_hit(input logic [RDBC_ADDR_W-1:0] a);
    addr_hit = a[RDBC_ADDR_W-1:RDBC_WORD_LSB] ==
               RDBC_REG_ADDR[RDBC_ADDR_W-1:RDBC_WORD_LSB];
  endfunction

  // Both halves of a write must be held and the last answer taken
  assign wr_fire = aw_done_q && w_done_q && !s_axi_bvalid;
  assign wr_hit  = addr_hit(awaddr_q);

  rdbc_decode u_decode
  (
    .cfg             (cfg_q),
    .lin_accel       (lin_accel_d),
    .lin_accel_rsvd  (lin_accel_rsvd_d),
    .quad_accel      (quad_accel_d),
    .brake_ilim      (brake_ilim_d),
    .brake_ilim_rsvd (brake_ilim_rsvd_d)
  );

  // ----------------------------------------------------------------------
  // Write address and data capture
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      aw_done_q     <= 1'b0;
      awaddr_q      <= '0;
    end
    else if (s_axi_awready && s_axi_awvalid)
    begin
      s_axi_awready <= 1'b0;
      aw_done_q     <= 1'b1;
      awaddr_q      <= s_axi_awaddr;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_awready <= 1'b1;
      aw_done_q     <= 1'b0;
    end
    else if (!aw_done_q)
      s_axi_awready <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_wready <= 1'b0;
      w_done_q     <= 1'b0;
      wdata_q      <= '0;
      wstrb_q      <= '0;
    end
    else if (s_axi_wready && s_axi_wvalid)
    begin
      s_axi_wready <= 1'b0;
      w_done_q     <= 1'b1;
      wdata_q      <= s_axi_wdata;
      wstrb_q      <= s_axi_wstrb;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_wready <= 1'b1;
      w_done_q     <= 1'b0;
    end
    else if (!w_done_q)
      s_axi_wready <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // Write response
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RDBC_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RDBC_RESP_OKAY : RDBC_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------------
  // Bit 31 is read-only zero, so a stray one from software is dropped
  generate
    for (genvar b = 0; b < RDBC_STRB_W; b++)
    begin : g_byte
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          cfg_q[b*8 +: 8] <= RDBC_CFG_RESET[b*8 +: 8];
        else if (wr_fire && wr_hit && wstrb_q[b])
          cfg_q[b*8 +: 8] <= wdata_q[b*8 +: 8] &
                             RDBC_WRITE_MASK[b*8 +: 8];
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RDBC_RESP_OKAY;
    end
    else if (s_axi_arready && s_axi_arvalid)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= addr_hit(s_axi_araddr) ? cfg_q : '0;
      s_axi_rresp   <= addr_hit(s_axi_araddr) ? RDBC_RESP_OKAY
                                              : RDBC_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // Decoded settings
  // ----------------------------------------------------------------------
  // One cycle of lag after a write keeps every output a plain flip-flop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lin_accel_q       <= '0;
      lin_accel_rsvd_q  <= 1'b0;
      quad_accel_q      <= '0;
      brake_ilim_q      <= '0;
      brake_ilim_rsvd_q <= 1'b0;
      brake_kp_q        <= '0;
      brake_ki_q        <= '0;
    end
    else
    begin
      lin_accel_q       <= lin_accel_d;
      lin_accel_rsvd_q  <= lin_accel_rsvd_d;
      quad_accel_q      <= quad_accel_d;
      brake_ilim_q      <= brake_ilim_d;
      brake_ilim_rsvd_q <= brake_ilim_rsvd_d;
      brake_kp_q        <= cfg_q[RDBC_KP_MSB:RDBC_KP_LSB];
      brake_ki_q        <= cfg_q[RDBC_KI_MSB:RDBC_KI_LSB];
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_reset_zero;
    @(posedge aclk) !aresetn |=> cfg_q == RDBC_CFG_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("Config register not zero after reset");

  property p_full_write;
    @(posedge aclk) disable iff (!aresetn)
      wr_fire && wr_hit && (&wstrb_q) |=>
        cfg_q == ($past(wdata_q) & RDBC_WRITE_MASK) && s_axi_bvalid
        && s_axi_bresp == RDBC_RESP_OKAY;
  endproperty
  a_full_write: assert property (p_full_write)
    else $error("Full write did not land in config register");

  property p_lin_accel;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |->
        lin_accel_q == RDBC_A1_TABLE[$past(cfg_q[RDBC_A1_MSB:RDBC_A1_LSB])];
  endproperty
  a_lin_accel: assert property (p_lin_accel)
    else $error("Linear acceleration decode mismatch");

  property p_quad_accel;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |->
        quad_accel_q == RDBC_A2_TABLE[$past(cfg_q[RDBC_A2_MSB:RDBC_A2_LSB])];
  endproperty
  a_quad_accel: assert property (p_quad_accel)
    else $error("Quadratic acceleration decode mismatch");

  property p_brake_ilim;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $past(cfg_q[RDBC_ILIM_MSB:RDBC_ILIM_LSB])
        == RDBC_ILIM_RSVD |-> brake_ilim_rsvd_q && brake_ilim_q == '0;
  endproperty
  a_brake_ilim: assert property (p_brake_ilim)
    else $error("Reserved current limit code not flagged");

  property p_brake_kp;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |->
        brake_kp_q == $past(cfg_q[RDBC_KP_MSB:RDBC_KP_LSB]);
  endproperty
  a_brake_kp: assert property (p_brake_kp)
    else $error("Proportional gain does not follow its field");

  property p_brake_ki;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn, 2) |->
        brake_ki_q == $past(cfg_q[RDBC_KI_MSB:RDBC_KI_LSB])
        && $past(brake_ki_q) == $past(cfg_q[RDBC_KI_MSB:RDBC_KI_LSB], 2);
  endproperty
  a_brake_ki: assert property (p_brake_ki)
    else $error("Integral gain does not follow its field");

endmodule

`default_nettype wire

// *** verification/tb_reverse_drive_brake_config.sv ***
// Self-checking bench for the reverse-drive and braking register block.
// Assumes rdbc_pkg is compiled first; the bench is the only bus master.
`timescale 1ns/10ps
`default_nettype none

module tb_reverse_drive_brake_config;
  import rdbc_pkg::*;

  // ----------------------------------------------------------------
  // Signals and expected code tables
  // ----------------------------------------------------------------
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awaddr  = 12'h000;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata   = 32'h00000000;
  logic [3:0]  wstrb   = 4'h0;
  logic        wvalid  = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready  = 1'b0;
  logic [11:0] araddr  = 12'h000;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready  = 1'b0;
  logic [19:0] lin_q;
  logic        lin_rsvd_q;
  logic [19:0] quad_q;
  logic [7:0]  ilim_q;
  logic        ilim_rsvd_q;
  logic [9:0]  kp_q;
  logic [9:0]  ki_q;
  int          fail_count = 0;
  int          n_compared = 0;
  // Hundredths of Hz/s; unlisted codes Ch and Eh give zero
  localparam logic [19:0] lin_tab [16] = '{
    20'h00001, 20'h00005, 20'h00064, 20'h000fa, 20'h001f4, 20'h003e8,
    20'h009c4, 20'h01388, 20'h01d4c, 20'h02710, 20'h061a8, 20'h0c350,
    20'h00000, 20'h186a0, 20'h00000, 20'hf4240};
  localparam logic [19:0] quad_tab [16] = '{
    20'h00000, 20'h00005, 20'h00064, 20'h000fa, 20'h001f4, 20'h003e8,
    20'h009c4, 20'h01388, 20'h01d4c, 20'h02710, 20'h061a8, 20'h0c350,
    20'h124f8, 20'h186a0, 20'h7a120, 20'hf4240};
  // Sixteenths of an ampere; the reserved code gives zero
  localparam logic [7:0] ilim_tab [8] = '{
    8'h05, 8'h0a, 8'h14, 8'h1e, 8'h28, 8'h32, 8'h3c, 8'h00};

  always #12.5 aclk = ~aclk;

  rdbc_top dut
  (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready),
    .lin_accel_q(lin_q), .lin_accel_rsvd_q(lin_rsvd_q),
    .quad_accel_q(quad_q), .brake_ilim_q(ilim_q),
    .brake_ilim_rsvd_q(ilim_rsvd_q),
    .brake_kp_q(kp_q), .brake_ki_q(ki_q)
  );

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  // Hold delays bready, so the response must stand meanwhile
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                           input logic [3:0] s, input logic [1:0] er,
                           input int hold);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    repeat (hold) @(posedge aclk);
    if (hold > 1) chk("bvalid", 32'h1, 32'(bvalid));
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk("bresp", 32'(er), 32'(bresp));
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [11:0] a, input logic [31:0] ed,
                          input logic [1:0] er, input int hold);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    repeat (hold) @(posedge aclk);
    if (hold > 0) chk("rvalid", 32'h1, 32'(rvalid));
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    chk("rdata", ed, rdata);
    chk("rresp", 32'(er), 32'(rresp));
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Decoded outputs settle one edge after the write response
  task automatic check_outs(input logic [31:0] w);
    @(negedge aclk);
    chk("lin", 32'(lin_tab[w[30:27]]), 32'(lin_q));
    chk("lin_rsvd", 32'(w[30:27] == 4'hc || w[30:27] == 4'he),
        32'(lin_rsvd_q));
    chk("quad", 32'(quad_tab[w[26:23]]), 32'(quad_q));
    chk("ilim", 32'(ilim_tab[w[22:20]]), 32'(ilim_q));
    chk("ilim_rsvd", 32'(w[22:20] == 3'h7), 32'(ilim_rsvd_q));
    chk("kp", 32'(w[19:10]), 32'(kp_q));
    chk("ki", 32'(w[9:0]), 32'(ki_q));
    // Next request starts just after a rising edge, not on the falling one
    @(posedge aclk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] w;
    logic [31:0] e;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_read(RDBC_REG_ADDR, 32'h0, RDBC_RESP_OKAY, 0);
    check_outs(32'h0);
    // Rows: every code of each coded field, stalls of 0 to 2 cycles
    for (int i = 0; i < 16; i++)
    begin
      w = {1'b0, 4'(i), 4'(15 - i), 3'(i), 10'(i * 67), 10'(1023 - i * 61)};
      axi_write(RDBC_REG_ADDR, w, 4'hf, RDBC_RESP_OKAY, i % 3);
      check_outs(w);
      axi_read(RDBC_REG_ADDR, w, RDBC_RESP_OKAY, i % 2);
    end
    // Single byte lane write keeps the other lanes
    e = (w & 32'hffff00ff) | 32'h00005600;
    axi_write(RDBC_REG_ADDR, 32'h12345678, 4'h2, RDBC_RESP_OKAY, 0);
    check_outs(e);
    axi_read(RDBC_REG_ADDR, e, RDBC_RESP_OKAY, 0);
    // All ones: read-only top bit stays clear, reserved current-limit code flagged
    axi_write(RDBC_REG_ADDR, 32'hffffffff, 4'hf, RDBC_RESP_OKAY, 3);
    check_outs(32'h7fffffff);
    axi_read(RDBC_REG_ADDR, 32'h7fffffff, RDBC_RESP_OKAY, 2);
    // Unmapped neighbours are refused and store nothing
    axi_write(12'h20c, 32'h0, 4'hf, RDBC_RESP_SLVERR, 0);
    axi_read(12'h204, 32'h0, RDBC_RESP_SLVERR, 0);
    axi_read(RDBC_REG_ADDR, 32'h7fffffff, RDBC_RESP_OKAY, 0);
    // Second reset in mid-run clears the word again
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_read(RDBC_REG_ADDR, 32'h0, RDBC_RESP_OKAY, 0);
    check_outs(32'h0);
    close_out();
  end

  // A hung handshake would otherwise stall the run for ever
  initial
  begin
    repeat (5000) @(posedge aclk);
    fail_count++;
    close_out();
  end

endmodule

`default_nettype wire
